// ---- src/pce_cfg_header.sv ----
// Configuration header bank of the Ethernet function, reached by configuration cycles.
// Assumes the target logic presents each decoded configuration access as a one-cycle request on the bus clock
// and that bus event pulses come from logic on the same clock.
//
// Notes on behaviour
// - Header follows bus 2.1 configuration rules.
// - Software reset leaves configuration values untouched.
// - Hardware reset restores every default value.
// - Reserved locations ignore writes, read zero.
// - Decode dwords 00h to 44h only.
// - Read-only identity, EEPROM values when auto-loaded.
// - Status upper half, command lower half.
// - Parity error flag sets regardless of response.
// - Write one clears parity, system error flags.
// - System error flag sets on each assertion.
// - Master and target abort received flags.
// - Sent target abort flag on target abort.
// - Select timing field reads binary 01.
// - Master data parity needs three conditions.
// - Fast back-to-back capable reads one.
// - User definable features bit reads zero.
// - Only configuration cycles reach these registers.
`timescale 1ns/1ps
module pce_cfg_header #(
    parameter logic [15:0] DEVICE_ID = 16'h5A01,    // Arbitrary value.
    parameter logic [15:0] VENDOR_ID = 16'hF0E1,    // Arbitrary value.
    parameter logic [31:0] SUBSYS_ID = 32'h0000_0000, // Arbitrary value.
    parameter logic [7:0] INT_PIN = 8'h01,
    parameter logic [31:0] PMC_VALUE = 32'h0000_0001
) (
    input logic sys_clk_i,               // Bus clock.
    input logic rstn_i,                  // Hardware reset, asynchronous, active low.
    input logic cfg_req_i,               // Configuration access to this function, one cycle.
    input logic cfg_we_i,                // 1 write, 0 read.
    input logic [5:0] cfg_dw_addr_i,     // Dword address, byte offset bits 7:2.
    input logic [3:0] cfg_be_i,          // Byte enables, active high.
    input logic [31:0] cfg_wdata_i,      // Write data.
    output logic [31:0] cfg_rdata_o,     // Read data, valid with ack.
    output logic cfg_ack_o,              // Access done, one cycle after request.
    input logic autoload_en_i,           // EEPROM auto-load enabled.
    input logic ee_id_valid_i,           // EEPROM identity words are valid, pulse.
    input logic [15:0] ee_device_id_i,   // Device code from EEPROM.
    input logic [15:0] ee_vendor_id_i,   // Vendor code from EEPROM.
    input logic par_err_det_i,           // Parity error detected, pulse.
    input logic serr_sent_i,             // This function drove the system error line, pulse.
    input logic master_abort_i,          // Own master cycle ended in master abort, pulse.
    input logic target_abort_rcvd_i,     // Own master cycle ended in target abort, pulse.
    input logic target_abort_sent_i,     // Target cycle ended by us with target abort, pulse.
    input logic perr_seen_i,             // Parity error line driven or seen, pulse.
    input logic master_xfer_i,           // This function is master of the current transfer.
    output logic [15:0] command_o,       // Command bits in force.
    output logic [7:0] latency_timer_o,  // Latency timer setting.
    output logic [31:0] io_base_o,       // I/O base address register.
    output logic [31:0] mem_base_o,      // Memory base address register.
    output logic [31:0] rom_base_o,      // Expansion ROM base register.
    output logic [7:0] int_line_o,       // Interrupt line setting.
    output logic [1:0] power_state_o     // Power state field.
);

    logic [31:0] id_q;
    logic [15:0] cmd_q;
    logic [31:0] lat_q;
    logic [31:0] iobar_q;
    logic [31:0] membar_q;
    logic [31:0] rom_q;
    logic [31:0] int_q;
    logic [31:0] pmcsr_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic [31:0] cs_rd;
    logic [31:0] rd_val;
    logic cs_wr;
    logic perr_resp;

    pce_flag_if #(.N(pce_pkg::PCE_NFLAGS)) fl ();

    pce_sticky_flags #(
        .N(pce_pkg::PCE_NFLAGS)
    ) u_flags (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .fl(fl)
    );

    // True when the dword address names the given byte offset.
    function automatic logic at_off(input logic [5:0] dw, input logic [7:0] off);
        at_off = ({dw, 2'b00} == off);
    endfunction

    // Merges write data into a register under byte enables and the writable mask.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
        merge = (old & ~m) | (wd & m);
    endfunction

    // True for a write to the given offset in this cycle.
    function automatic logic wr_at(input logic [7:0] off);
        wr_at = cfg_req_i && cfg_we_i && at_off(cfg_dw_addr_i, off);
    endfunction

    assign cs_wr = cfg_req_i && cfg_we_i && at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_CS);
    assign perr_resp = cmd_q[pce_pkg::PCE_BIT_PERR_RESP];

    // Flag events, taken in the cycle the bus logic reports them.
    always_comb
    begin
        fl.set = '0;
        fl.set[pce_pkg::PCE_F_DPE] = par_err_det_i;
        fl.set[pce_pkg::PCE_F_SSE] = serr_sent_i;
        fl.set[pce_pkg::PCE_F_RMA] = master_abort_i;
        fl.set[pce_pkg::PCE_F_RTA] = target_abort_rcvd_i;
        fl.set[pce_pkg::PCE_F_STA] = target_abort_sent_i;
        fl.set[pce_pkg::PCE_F_MDP] = perr_seen_i && master_xfer_i && perr_resp;
    end

    // Writing one clears a flag, writing zero leaves it; all flags lie in byte lane 3.
    always_comb
    begin
        fl.clr = '0;
        if (cs_wr && cfg_be_i[3])
        begin
            fl.clr[pce_pkg::PCE_F_DPE] = cfg_wdata_i[pce_pkg::PCE_BIT_DPE];
            fl.clr[pce_pkg::PCE_F_SSE] = cfg_wdata_i[pce_pkg::PCE_BIT_SSE];
            fl.clr[pce_pkg::PCE_F_RMA] = cfg_wdata_i[pce_pkg::PCE_BIT_RMA];
            fl.clr[pce_pkg::PCE_F_RTA] = cfg_wdata_i[pce_pkg::PCE_BIT_RTA];
            fl.clr[pce_pkg::PCE_F_STA] = cfg_wdata_i[pce_pkg::PCE_BIT_STA];
            fl.clr[pce_pkg::PCE_F_MDP] = cfg_wdata_i[pce_pkg::PCE_BIT_MDP];
        end
    end

    // Status half: sticky flags over the fixed bits, command half below it.
    always_comb
    begin
        cs_rd = pce_pkg::PCE_CS_FIXED;
        cs_rd[pce_pkg::PCE_BIT_DPE] = fl.q[pce_pkg::PCE_F_DPE];
        cs_rd[pce_pkg::PCE_BIT_SSE] = fl.q[pce_pkg::PCE_F_SSE];
        cs_rd[pce_pkg::PCE_BIT_RMA] = fl.q[pce_pkg::PCE_F_RMA];
        cs_rd[pce_pkg::PCE_BIT_RTA] = fl.q[pce_pkg::PCE_F_RTA];
        cs_rd[pce_pkg::PCE_BIT_STA] = fl.q[pce_pkg::PCE_F_STA];
        cs_rd[pce_pkg::PCE_BIT_MDP] = fl.q[pce_pkg::PCE_F_MDP];
        cs_rd[15:0] = cmd_q;
    end

    // Identity follows the EEPROM once it has loaded; writes never reach it.
    // The load is taken after reset, so the reset value itself stays a constant.
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            id_q <= {DEVICE_ID, VENDOR_ID};
        end
        else if (autoload_en_i && ee_id_valid_i)
        begin
            id_q <= {ee_device_id_i, ee_vendor_id_i};
        end
    end

    // Only the hardware reset pin resets the bank; a function soft reset never reaches it.
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cmd_q <= pce_pkg::PCE_CS_RESET[15:0];
        end
        else if (cs_wr)
        begin
            cmd_q <= 16'(merge({16'h0000, cmd_q}, cfg_wdata_i, cfg_be_i, pce_pkg::PCE_CS_WMASK));
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lat_q <= pce_pkg::PCE_LAT_RESET;
        end
        else if (wr_at(pce_pkg::PCE_OFF_LAT))
        begin
            lat_q <= merge(lat_q, cfg_wdata_i, cfg_be_i, pce_pkg::PCE_LAT_WMASK);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            iobar_q <= pce_pkg::PCE_IOBAR_RESET;
            membar_q <= pce_pkg::PCE_MEMBAR_RESET;
        end
        else
        begin
            if (wr_at(pce_pkg::PCE_OFF_IOBAR))
            begin
                iobar_q <= merge(iobar_q, cfg_wdata_i, cfg_be_i, pce_pkg::PCE_IOBAR_WMASK);
            end
            if (wr_at(pce_pkg::PCE_OFF_MEMBAR))
            begin
                membar_q <= merge(membar_q, cfg_wdata_i, cfg_be_i, pce_pkg::PCE_MEMBAR_WMASK);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rom_q <= pce_pkg::PCE_ROM_RESET;
        end
        else if (wr_at(pce_pkg::PCE_OFF_ROM))
        begin
            rom_q <= merge(rom_q, cfg_wdata_i, cfg_be_i, pce_pkg::PCE_ROM_WMASK);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            int_q <= pce_pkg::PCE_INT_RESET;
            pmcsr_q <= pce_pkg::PCE_PMCSR_RESET;
        end
        else
        begin
            if (wr_at(pce_pkg::PCE_OFF_INT))
            begin
                int_q <= merge(int_q, cfg_wdata_i, cfg_be_i, pce_pkg::PCE_INT_WMASK);
            end
            if (wr_at(pce_pkg::PCE_OFF_PMCSR))
            begin
                pmcsr_q <= merge(pmcsr_q, cfg_wdata_i, cfg_be_i, pce_pkg::PCE_PMCSR_WMASK);
            end
        end
    end

    // Read decode; anything outside the implemented dwords reads zero.
    always_comb
    begin
        if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_ID))
        begin
            rd_val = id_q;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_CS))
        begin
            rd_val = cs_rd;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_REV))
        begin
            rd_val = pce_pkg::PCE_REV_VALUE;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_LAT))
        begin
            rd_val = lat_q;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_IOBAR))
        begin
            rd_val = iobar_q;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_MEMBAR))
        begin
            rd_val = membar_q;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_SUBID))
        begin
            rd_val = SUBSYS_ID;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_ROM))
        begin
            rd_val = rom_q;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_CAP))
        begin
            rd_val = pce_pkg::PCE_CAP_VALUE;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_INT))
        begin
            rd_val = {16'h0000, INT_PIN, int_q[7:0]};
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_PMC))
        begin
            rd_val = PMC_VALUE;
        end
        else if (at_off(cfg_dw_addr_i, pce_pkg::PCE_OFF_PMCSR))
        begin
            rd_val = pmcsr_q;
        end
        else
        begin
            rd_val = 32'h0000_0000;
        end
    end

    // Every access is answered the next cycle, so the target logic never waits on the bank.
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= cfg_req_i;
            rdata_q <= (cfg_req_i && !cfg_we_i) ? rd_val : 32'h0000_0000;
        end
    end

    assign cfg_ack_o = ack_q;
    assign cfg_rdata_o = rdata_q;
    assign command_o = cmd_q;
    assign latency_timer_o = lat_q[15:8];
    assign io_base_o = iobar_q;
    assign mem_base_o = membar_q;
    assign rom_base_o = rom_q;
    assign int_line_o = int_q[7:0];
    assign power_state_o = pmcsr_q[1:0];

    access_ack_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        cfg_req_i |=> cfg_ack_o ##1 !cfg_ack_o || $past(cfg_req_i))
        else $error("Configuration access not acknowledged next cycle.");

    reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_req_i && !cfg_we_i && ({cfg_dw_addr_i, 2'b00} > pce_pkg::PCE_OFF_PMCSR))
        |=> (cfg_rdata_o == 32'h0000_0000))
        else $error("Reserved location did not read zero.");

    id_read_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_req_i && !cfg_we_i && cfg_dw_addr_i == 6'h00) |=> (cfg_rdata_o == $past(id_q)))
        else $error("Identity read returned wrong value.");

    cs_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_req_i && !cfg_we_i && cfg_dw_addr_i == 6'h01)
        |=> (cfg_rdata_o[26:25] == 2'b01 && cfg_rdata_o[23] && !cfg_rdata_o[22]))
        else $error("Fixed status bits read wrong.");

    parity_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        par_err_det_i |=> cs_rd[31] ##1 (cs_rd[31] || $past(cs_wr && cfg_be_i[3] && cfg_wdata_i[31])))
        else $error("Detected parity flag not set.");

    serr_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        serr_sent_i |=> cs_rd[30])
        else $error("Signaled system error flag not set.");

    abort_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (master_abort_i || target_abort_rcvd_i)
        |=> ((cs_rd[29] || !$past(master_abort_i)) && (cs_rd[28] || !$past(target_abort_rcvd_i))))
        else $error("Received abort flags not set.");

    sent_abort_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        target_abort_sent_i |=> cs_rd[27])
        else $error("Sent target abort flag not set.");

    mdp_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(cs_rd[24]) |-> $past(perr_seen_i && master_xfer_i && perr_resp))
        else $error("Master data parity flag set without all conditions.");

    zero_keeps_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cs_wr && cs_rd[31] && !cfg_wdata_i[31]) |=> cs_rd[31])
        else $error("Writing zero cleared the parity flag.");

    id_write_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (cfg_req_i && cfg_we_i && !(autoload_en_i && ee_id_valid_i)) |=> $stable(id_q))
        else $error("Identity register changed on a write.");

endmodule

// ---- src/pce_pkg.sv ----
// Package of the configuration header bank: offsets, reset values, write masks and flag layout.
// Assumes one clock, the bus clock, for the whole bank and its event sources.
package pce_pkg;

    // Byte offsets of the implemented dwords.
    localparam logic [7:0] PCE_OFF_ID = 8'h00;
    localparam logic [7:0] PCE_OFF_CS = 8'h04;
    localparam logic [7:0] PCE_OFF_REV = 8'h08;
    localparam logic [7:0] PCE_OFF_LAT = 8'h0C;
    localparam logic [7:0] PCE_OFF_IOBAR = 8'h10;
    localparam logic [7:0] PCE_OFF_MEMBAR = 8'h14;
    localparam logic [7:0] PCE_OFF_SUBID = 8'h2C;
    localparam logic [7:0] PCE_OFF_ROM = 8'h30;
    localparam logic [7:0] PCE_OFF_CAP = 8'h34;
    localparam logic [7:0] PCE_OFF_INT = 8'h3C;
    localparam logic [7:0] PCE_OFF_PMC = 8'h40;
    localparam logic [7:0] PCE_OFF_PMCSR = 8'h44;

    // Values after hardware reset and fixed read values.
    localparam logic [31:0] PCE_CS_RESET = 32'h0290_0000;
    localparam logic [31:0] PCE_CS_FIXED = 32'h0290_0000;
    localparam logic [31:0] PCE_REV_VALUE = 32'h0200_0001;
    localparam logic [31:0] PCE_LAT_RESET = 32'h0000_0000;
    localparam logic [31:0] PCE_IOBAR_RESET = 32'h0000_0001;
    localparam logic [31:0] PCE_MEMBAR_RESET = 32'h0000_0000;
    localparam logic [31:0] PCE_ROM_RESET = 32'h0000_0000;
    localparam logic [31:0] PCE_INT_RESET = 32'h0000_0000;
    localparam logic [31:0] PCE_PMCSR_RESET = 32'h0000_0000;
    localparam logic [31:0] PCE_CAP_VALUE = 32'h0000_0040;

    // Bits that software may change in each writable dword.
    localparam logic [31:0] PCE_CS_WMASK = 32'h0000_0347;
    localparam logic [31:0] PCE_LAT_WMASK = 32'h0000_FF00;
    localparam logic [31:0] PCE_IOBAR_WMASK = 32'hFFFF_FF00;
    localparam logic [31:0] PCE_MEMBAR_WMASK = 32'hFFFF_FF00;
    localparam logic [31:0] PCE_ROM_WMASK = 32'hFFFF_F801;
    localparam logic [31:0] PCE_INT_WMASK = 32'h0000_00FF;
    localparam logic [31:0] PCE_PMCSR_WMASK = 32'h0000_0003;

    // Sticky status flags, index inside the flag vector and bit in the dword.
    localparam int PCE_NFLAGS = 6;
    localparam int PCE_F_DPE = 0;
    localparam int PCE_F_SSE = 1;
    localparam int PCE_F_RMA = 2;
    localparam int PCE_F_RTA = 3;
    localparam int PCE_F_STA = 4;
    localparam int PCE_F_MDP = 5;
    localparam int PCE_BIT_DPE = 31;
    localparam int PCE_BIT_SSE = 30;
    localparam int PCE_BIT_RMA = 29;
    localparam int PCE_BIT_RTA = 28;
    localparam int PCE_BIT_STA = 27;
    localparam int PCE_BIT_MDP = 24;
    localparam int PCE_BIT_PERR_RESP = 6;

endpackage

// ---- src/pce_flag_if.sv ----
// Interface between the bank and its sticky flag store.
// Assumes set and clear are single-cycle pulses on the bus clock.
`timescale 1ns/1ps
interface pce_flag_if #(
    parameter int N = 6
);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] q;

    modport owner (input set, input clr, output q);
    modport user (output set, output clr, input q);
endinterface

// ---- src/pce_sticky_flags.sv ----
// Sticky status flags that hardware sets and software clears by writing one.
// Assumes set and clear arrive on the same clock as the flags.
`timescale 1ns/1ps
module pce_sticky_flags #(
    parameter int N = 6
) (
    input logic sys_clk_i,    // Bus clock.
    input logic rstn_i,       // Asynchronous reset, active low.
    pce_flag_if.owner fl      // Set, clear and flag state.
);

    logic [N-1:0] flag_q;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= (flag_q & ~fl.clr) | fl.set;
        end
    end

    assign fl.q = flag_q;

    set_wins_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (fl.set != '0) |=> ((flag_q & $past(fl.set)) == $past(fl.set)))
        else $error("Flag set was lost against a clear.");

    clear_works_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        ((fl.clr & ~fl.set) != '0) |=> ((flag_q & $past(fl.clr & ~fl.set)) == '0))
        else $error("Flag did not clear on a write of one.");

endmodule

// ---- tb/pce_host_model.sv ----
// Host bridge model that issues configuration reads and writes.
// Assumes the bank acks each access one cycle after the request edge.
`timescale 1ns/1ps
module pce_host_model (
    input logic sys_clk_i,            // Bus clock.
    input logic cfg_ack_i,            // Access done.
    input logic [31:0] cfg_rdata_i,   // Read data.
    output logic cfg_req_o,           // Request pulse.
    output logic cfg_we_o,            // Write select.
    output logic [5:0] cfg_dw_addr_o, // Dword address.
    output logic [3:0] cfg_be_o,      // Byte enables.
    output logic [31:0] cfg_wdata_o   // Write data.
);
    initial
    begin
        cfg_req_o = 1'b0;
        {cfg_we_o, cfg_dw_addr_o, cfg_be_o, cfg_wdata_o} = '0;
    end

    // Released lines carry the inverse, so a stale value never passes for a held one.
    task automatic access(input logic we, input logic [5:0] a, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ack);
        @(negedge sys_clk_i);
        cfg_req_o = 1'b1;
        {cfg_we_o, cfg_dw_addr_o, cfg_be_o, cfg_wdata_o} = {we, a, be, wd};
        @(negedge sys_clk_i);
        cfg_req_o = 1'b0;
        {cfg_we_o, cfg_dw_addr_o, cfg_be_o, cfg_wdata_o} = ~{we, a, be, wd};
        rd = cfg_rdata_i;
        ack = cfg_ack_i;
    endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the configuration header bank.
// Assumes pce_host_model issues every access and event pulses last one cycle.
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] DEV_ID = 16'hA5C3; // Arbitrary value.
    localparam logic [15:0] VEN_ID = 16'h3C5A; // Arbitrary value.
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic autoload = 1'b0;
    logic mxfer = 1'b0;
    logic [6:0] ev = 7'h00;
    logic [31:0] rdata, d, wdata, io_b, mem_b, rom_b, f;
    logic ack, req, we;
    logic [5:0] addr;
    logic [3:0] be;
    logic [15:0] cmd;
    logic [7:0] lat, intl;
    logic [1:0] pst;
    int miscompares = 0;
    int checks = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    pce_host_model host_u (.sys_clk_i(sys_clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata), .cfg_req_o(req),
        .cfg_we_o(we), .cfg_dw_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata));

    pce_cfg_header #(.DEVICE_ID(DEV_ID), .VENDOR_ID(VEN_ID)) dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .cfg_req_i(req), .cfg_we_i(we), .cfg_dw_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_ack_o(ack), .autoload_en_i(autoload), .ee_id_valid_i(ev[6]),
        .ee_device_id_i(16'h1234), .ee_vendor_id_i(16'h5678), .par_err_det_i(ev[0]), .serr_sent_i(ev[1]),
        .master_abort_i(ev[2]), .target_abort_rcvd_i(ev[3]), .target_abort_sent_i(ev[4]),
        .perr_seen_i(ev[5]), .master_xfer_i(mxfer), .command_o(cmd), .latency_timer_o(lat),
        .io_base_o(io_b), .mem_base_o(mem_b), .rom_base_o(rom_b), .int_line_o(intl), .power_state_o(pst));

    // Upper half: value after all ones were written everywhere; lower half: value after reset.
    function automatic logic [63:0] exp_val(input logic [5:0] a);
        case ({a, 2'b00})
            8'h00: exp_val = {2{DEV_ID, VEN_ID}};
            8'h04: exp_val = {32'h0290_0347, 32'h0290_0000};
            8'h08: exp_val = {2{32'h0200_0001}};
            8'h0C: exp_val = {32'h0000_FF00, 32'h0000_0000};
            8'h10: exp_val = {32'hFFFF_FF01, 32'h0000_0001};
            8'h14: exp_val = {32'hFFFF_FF00, 32'h0000_0000};
            8'h30: exp_val = {32'hFFFF_F801, 32'h0000_0000};
            8'h34: exp_val = {2{32'h0000_0040}};
            8'h3C: exp_val = {32'h0000_01FF, 32'h0000_0100};
            8'h40: exp_val = {2{32'h0000_0001}};
            8'h44: exp_val = {32'h0000_0003, 32'h0000_0000};
            default: exp_val = 64'h0000_0000_0000_0000;
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        checks++;
        if (got !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] b, input logic [31:0] wd);
        logic k;
        host_u.access(w, a, b, wd, d, k);
        chk("ack", 32'h0000_0001, {31'h0000_0000, k});
    endtask

    task automatic rd(input logic [5:0] a);
        acc(1'b0, a, 4'h0, 32'h0000_0000);
    endtask

    task automatic pulse(input logic [6:0] m);
        @(negedge sys_clk_i);
        ev = m;
        @(negedge sys_clk_i);
        ev = 7'h00;
    endtask

    task automatic map(input logic ones);
        for (int i = 0; i < 64; i++)
        begin
            logic [63:0] e;
            e = exp_val(i[5:0]);
            rd(i[5:0]);
            chk("map", ones ? e[63:32] : e[31:0], d);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (12) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        map(1'b0);
        for (int i = 0; i < 64; i++)
            acc(1'b1, i[5:0], 4'hF, 32'hFFFF_FFFF);
        map(1'b1);
        chk("cmd lat int", 32'h0347_FFFF, {cmd, lat, intl});
        chk("io", 32'hFFFF_FF01, io_b);
        chk("mem", 32'hFFFF_FF00, mem_b);
        chk("rom", 32'hFFFF_F801, rom_b);
        chk("pwr", 32'h0000_0003, {30'h0000_0000, pst});
        acc(1'b1, 6'h03, 4'h1, 32'h0000_0000);
        rd(6'h03);
        chk("lane0", 32'h0000_FF00, d);
        acc(1'b1, 6'h03, 4'h2, 32'h0000_0000);
        rd(6'h03);
        chk("lane1", 32'h0000_0000, d);
        acc(1'b1, 6'h01, 4'h3, 32'h0000_0000);
        for (int i = 0; i < 5; i++)
        begin
            f = 32'h0000_0001 << (31 - i);
            pulse(7'h01 << i);
            rd(6'h01);
            chk("flag set", 32'h0290_0000 | f, d);
            acc(1'b1, 6'h01, 4'h8, 32'h0000_0000);
            rd(6'h01);
            chk("flag kept", 32'h0290_0000 | f, d);
            acc(1'b1, 6'h01, 4'h8, f);
            rd(6'h01);
            chk("flag clr", 32'h0290_0000, d);
        end
        mxfer = 1'b1;
        pulse(7'h20);
        rd(6'h01);
        chk("mdp resp off", 32'h0290_0000, d);
        acc(1'b1, 6'h01, 4'h3, 32'h0000_0040);
        mxfer = 1'b0;
        pulse(7'h20);
        rd(6'h01);
        chk("mdp no master", 32'h0290_0040, d);
        mxfer = 1'b1;
        pulse(7'h20);
        rd(6'h01);
        chk("mdp set", 32'h0390_0040, d);
        acc(1'b1, 6'h01, 4'h8, 32'h0100_0000);
        rd(6'h01);
        chk("mdp clr", 32'h0290_0040, d);
        fork
            pulse(7'h01);
            acc(1'b1, 6'h01, 4'h8, 32'h8000_0000);
        join
        rd(6'h01);
        chk("set wins", 32'h8290_0040, d);
        pulse(7'h40);
        rd(6'h00);
        chk("id no load", {DEV_ID, VEN_ID}, d);
        autoload = 1'b1;
        pulse(7'h40);
        acc(1'b1, 6'h00, 4'hF, 32'h0000_0000);
        rd(6'h00);
        chk("id loaded", 32'h1234_5678, d);
        pulse(7'h1F);
        rd(6'h01);
        chk("all flags", 32'hFA90_0040, d);
        rstn_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        map(1'b0);
        report_and_stop();
    end
endmodule
